//--- src/fpb_consts.svh
/*
 * Constants of the front-panel button sequencer: register offsets, field
 * positions, reset values and timing figures.
 * Assumes a 125 MHz system clock; included by bare name, definitions only.
 */
`ifndef FPB_CONSTS_SVH
`define FPB_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ         125
`define TICK_US         1000
`define TICK_CYC        (`TICK_US * `CLK_MHZ)
`define HOLD_SLOW_MS    5000
`define HOLD_FAST_MS    10000
`define CONFIRM_MS      3000
`define CONFIRM_PRESSES 3
`define LOCK_WIN_MS     100
`define DARK_MS         1000
`define FB_MS           768
`define FB_BIT          7
`define SLOW_BIT        9
`define FAST_BIT        7

// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_ANALOG      8'h08
`define REG_IRQ_STAT    8'h0C
`define REG_IRQ_MASK    8'h10
`define CTRL_VSEL_OFF   0
`define CTRL_ASEL_OFF   1
`define CTRL_DHCP       2
`define CTRL_LOCK       3
`define EV_VID          0
`define EV_AUD          1
`define EV_USER         2
`define EV_LOCK         3
`define EV_DHCP         4
`define EV_FACT         5
`define EV_N            6
`define ANALOG_RST      4'h1
`define MASK_RST        6'h00
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// ----------------------------------------
// Selections
// ----------------------------------------
`define N_IN            4
`define VID_AUTO        3'h4
`define AUD_EMB         2'h0
`define AUD_LAST        2'h2
`define NLED            5

`endif

//--- src/fpb_pkg.sv
/*
 * Types shared by the front-panel button sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpb_pkg;

	// Hold-and-confirm gesture states of the user-action button
	typedef enum {
		GS_IDLE,
		GS_HELD,
		GS_ARM_D,
		GS_ARM_F,
		GS_CONF_D,
		GS_CONF_F,
		GS_DARK_D,
		GS_DARK_F
	} fpb_gest_t;

	typedef logic [2:0] fpb_vid_t;
	typedef logic [1:0] fpb_aud_t;

endpackage : fpb_pkg

//--- src/fpb_press.sv
/*
 * Press detector: registered level and one-cycle rising-edge pulse for each
 * button.
 * Assumes button levels already synchronous to aclk and free of bounce.
 */
`timescale 1ns/1ps
`default_nettype none

module fpb_press #(
	parameter int N = 4
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [N-1:0] btn,
	output logic      [N-1:0] level,
	output logic      [N-1:0] rise
);

	// ----------------------------------------
	// Per-button edge detect
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_btn
			// Level and edge taken in the same edge, so rise lines up with level
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					level[i] <= 1'b0;
					rise[i]  <= 1'b0;
				end else begin
					level[i] <= btn[i];
					rise[i]  <= btn[i] & ~level[i];
				end
			end
		end
	endgenerate

endmodule : fpb_press

`default_nettype wire

//--- src/fpb_sequencer.sv
/*
 * Front-panel button sequencer: video and audio selection, control lock,
 * DHCP and factory-reset hold gestures, LED feedback, event interrupt and
 * an AXI4-Lite register slave.
 * Assumes synchronous debounced buttons, a 125 MHz aclk and that stored
 * settings persist outside this block across a reboot.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpb_consts.svh"

module fpb_sequencer
	import fpb_pkg::*;
#(
	parameter logic [16:0] P_TICK_CYC     = 17'(`TICK_CYC),
	parameter logic [13:0] P_HOLD_SLOW_MS = 14'(`HOLD_SLOW_MS),
	parameter logic [13:0] P_HOLD_FAST_MS = 14'(`HOLD_FAST_MS),
	parameter logic [13:0] P_CONFIRM_MS   = 14'(`CONFIRM_MS)
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        btn_video,
	input  wire logic        btn_audio,
	input  wire logic        user_action_button,
	input  wire logic        btn_reset,
	output fpb_vid_t         video_route,
	output fpb_aud_t         audio_route,
	output logic [1:0]       embed_port,
	output logic [`NLED-1:0] led_front,
	output logic             heartbeat_led,
	output logic             dhcp_enable,
	output logic             user_event,
	output logic             factory_restore,
	output logic             reboot_req,
	output logic             irq
);

	// ----------------------------------------
	// Buttons and millisecond time base
	// ----------------------------------------
	logic [3:0]      b_lvl;
	logic [3:0]      b_rise;
	logic [16:0]     div;
	logic            tick;
	logic [9:0]      ms_free;
	wire             div_end = (div == P_TICK_CYC - 17'd1);
	wire             v_rise  = b_rise[0];
	wire             a_rise  = b_rise[1];
	wire             u_rise  = b_rise[2];
	wire             r_rise  = b_rise[3];
	wire             u_lvl   = b_lvl[2];

	fpb_press #(.N(4)) u_press (
		.aclk    (aclk),
		.aresetn (aresetn),
		.btn     ({btn_reset, user_action_button, btn_audio, btn_video}),
		.level   (b_lvl),
		.rise    (b_rise)
	);

	// One-cycle tick per ms; all slow timing counts these
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div     <= 17'h00000;
			tick    <= 1'b0;
			ms_free <= 10'h000;
		end else begin
			div     <= div_end ? 17'h00000 : div + 17'd1;
			tick    <= div_end;
			ms_free <= tick ? ms_free + 10'd1 : ms_free;
		end
	end

	// ----------------------------------------
	// Settings and selection state
	// ----------------------------------------
	logic            vsel_off;
	logic            asel_off;
	logic            lock;
	logic [3:0]      analog;
	fpb_vid_t        vid;
	fpb_aud_t        aud;
	fpb_gest_t       gst;
	fpb_gest_t       next_gst;
	logic [13:0]     g_ms;
	logic [1:0]      presses;
	logic            pend_a;
	logic            pend_u;
	logic [6:0]      win;
	logic [9:0]      fb_ms;

	// ----------------------------------------
	// Combo window: audio and user within the lock window
	// ----------------------------------------
	// Both presses are held back for the window, so a lock combo steps audio only if the user press
	// lands in the cycle that closes the audio window; costs 100 ms of latency on those two buttons.
	wire gidle   = (gst == GS_IDLE);
	wire u_in    = u_rise & gidle;
	wire combo   = (a_rise & (u_in | pend_u)) | (u_in & pend_a);
	wire win_end = tick & (pend_a | pend_u) & (win == 7'(`LOCK_WIN_MS - 1));
	wire a_exp   = pend_a & ~pend_u & win_end;
	wire u_exp   = pend_u & ~pend_a & win_end;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_a <= 1'b0;
			pend_u <= 1'b0;
			win    <= 7'h00;
		end else begin
			pend_a <= combo ? 1'b0 : a_rise ? 1'b1 : win_end ? 1'b0 : pend_a;
			pend_u <= combo ? 1'b0 : u_in ? 1'b1 : win_end ? 1'b0 : pend_u;
			if (a_rise | u_in)
				win <= 7'h00;
			else if (tick & (pend_a | pend_u))
				win <= win + 7'd1;
		end
	end

	// ----------------------------------------
	// Press decoding
	// ----------------------------------------
	wire       vid_press = v_rise & ~lock;
	wire       aud_press = a_exp & ~lock;
	wire       user_ev   = u_exp & ~lock;
	wire       vid_go    = vid_press & ~vsel_off;
	wire       aud_go    = aud_press & ~asel_off;
	wire       fb_start  = combo | (lock & (v_rise | a_exp | u_exp));
	wire       vid_an    = (vid != `VID_AUTO) & analog[vid[1:0]];
	// Autoselect sits after the last input, then the order wraps
	wire [2:0] vid_nx    = (vid == `VID_AUTO) ? 3'h0 : vid + 3'd1;
	wire [1:0] aud_inc   = (aud == `AUD_LAST) ? `AUD_EMB : aud + 2'd1;
	// Analog video carries no audio, so embedded is stepped over
	wire [1:0] aud_nx    = (aud_inc == `AUD_EMB && vid_an) ? aud_inc + 2'd1 : aud_inc;

	// ----------------------------------------
	// Gesture state machine
	// ----------------------------------------
	wire g_chg     = (gst != next_gst);
	wire conf3     = u_rise & (presses == 2'(`CONFIRM_PRESSES - 1));
	wire dhcp_done = (gst == GS_CONF_D) & (next_gst == GS_DARK_D);
	wire fact_go   = (gst == GS_CONF_F) & (next_gst == GS_DARK_F);
	wire fact_done = (gst == GS_DARK_F) & (next_gst == GS_IDLE);

	always_comb begin
		next_gst = gst;
		case (gst)
			GS_IDLE: begin
				if (u_in & ~lock & ~combo)
					next_gst = GS_HELD;
			end
			GS_HELD: begin
				if (combo | ~u_lvl)
					next_gst = GS_IDLE;
				else if (g_ms >= P_HOLD_SLOW_MS)
					next_gst = GS_ARM_D;
			end
			GS_ARM_D: begin
				if (~u_lvl)
					next_gst = GS_CONF_D;
				else if (g_ms >= P_HOLD_FAST_MS - P_HOLD_SLOW_MS)
					next_gst = GS_ARM_F;
			end
			GS_ARM_F: begin
				if (~u_lvl)
					next_gst = GS_CONF_F;
			end
			GS_CONF_D: begin
				if (conf3)
					next_gst = GS_DARK_D;
				else if (g_ms >= P_CONFIRM_MS)
					next_gst = GS_IDLE;
			end
			GS_CONF_F: begin
				if (conf3)
					next_gst = GS_DARK_F;
				else if (g_ms >= P_CONFIRM_MS)
					next_gst = GS_IDLE;
			end
			GS_DARK_D, GS_DARK_F: begin
				if (g_ms >= 14'(`DARK_MS))
					next_gst = GS_IDLE;
			end
			default: next_gst = GS_IDLE;
		endcase
	end

	// Timer restarts on each state change and saturates while held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gst     <= GS_IDLE;
			g_ms    <= 14'h0000;
			presses <= 2'h0;
		end else begin
			gst <= next_gst;
			if (g_chg)
				g_ms <= 14'h0000;
			else if (tick && g_ms != 14'h3FFF)
				g_ms <= g_ms + 14'd1;
			if (g_chg)
				presses <= 2'h0;
			else if (u_rise)
				presses <= presses + 2'd1;
		end
	end

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic [`EV_N-1:0] irq_stat;
	logic [`EV_N-1:0] irq_mask;
	wire              wr_en   = awready & awvalid & wvalid;
	wire              rd_en   = arready & arvalid;
	wire              wr_ctrl = wr_en & (awaddr == `REG_CTRL) & wstrb[0];
	wire              wr_an   = wr_en & (awaddr == `REG_ANALOG) & wstrb[0];
	wire              wr_mask = wr_en & (awaddr == `REG_IRQ_MASK) & wstrb[0];
	wire              rd_stat = rd_en & (araddr == `REG_IRQ_STAT);
	wire              w_map   = (awaddr == `REG_CTRL) | (awaddr == `REG_STATUS) |
	                            (awaddr == `REG_ANALOG) | (awaddr == `REG_IRQ_STAT) |
	                            (awaddr == `REG_IRQ_MASK);
	wire [31:0]       st_word = {24'h000000, lock, dhcp_enable, aud, 1'b0, vid};
	wire [31:0]       ct_word = {28'h0000000, lock, dhcp_enable, asel_off, vsel_off};
	logic [31:0]      rd_mux;
	logic             rd_hit;

	always_comb begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		case (araddr)
			`REG_CTRL:     rd_mux = ct_word;
			`REG_STATUS:   rd_mux = st_word;
			`REG_ANALOG:   rd_mux = {28'h0000000, analog};
			`REG_IRQ_STAT: rd_mux = {26'h0000000, irq_stat};
			`REG_IRQ_MASK: rd_mux = {26'h0000000, irq_mask};
			default:       rd_hit = 1'b0;
		endcase
	end

	// Write: address and data taken together, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OKAY;
		end else begin
			awready <= awvalid & wvalid & ~bvalid & ~awready;
			wready  <= awvalid & wvalid & ~bvalid & ~awready;
			if (wr_en) begin
				bvalid <= 1'b1;
				bresp  <= w_map ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bready)
				bvalid <= 1'b0;
		end
	end

	// Read: one cycle from accept to data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= `RESP_OKAY;
		end else begin
			arready <= arvalid & ~arready & ~rvalid;
			if (rd_en) begin
				rvalid <= 1'b1;
				rdata  <= rd_mux;
				rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Settings registers
	// ----------------------------------------
	// Hardware gestures win over a software write in the same cycle.
	// Nothing here is cleared by the reset button: that only requests a
	// reboot from the outside world, which keeps its stored settings.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vsel_off    <= 1'b0;
			asel_off    <= 1'b0;
			dhcp_enable <= 1'b0;
			lock        <= 1'b0;
			analog      <= `ANALOG_RST;
			irq_mask    <= `MASK_RST;
		end else begin
			if (fact_go) begin
				vsel_off    <= 1'b0;
				asel_off    <= 1'b0;
				dhcp_enable <= 1'b0;
				lock        <= 1'b0;
				analog      <= `ANALOG_RST;
			end else begin
				if (wr_ctrl) begin
					vsel_off <= wdata[`CTRL_VSEL_OFF];
					asel_off <= wdata[`CTRL_ASEL_OFF];
				end
				if (dhcp_done)
					dhcp_enable <= 1'b1;
				else if (wr_ctrl)
					dhcp_enable <= wdata[`CTRL_DHCP];
				if (combo)
					lock <= ~lock;
				else if (wr_ctrl)
					lock <= wdata[`CTRL_LOCK];
				if (wr_an)
					analog <= wdata[3:0];
			end
			if (wr_mask)
				irq_mask <= wdata[`EV_N-1:0];
		end
	end

	// ----------------------------------------
	// Selection registers
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vid <= 3'h0;
			aud <= `AUD_EMB;
		end else if (fact_go) begin
			vid <= 3'h0;
			aud <= `AUD_EMB;
		end else begin
			if (vid_go)
				vid <= vid_nx;
			if (aud_go)
				aud <= aud_nx;
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	wire [`EV_N-1:0] ev = {fact_done, dhcp_done, combo, user_ev, aud_press, vid_press};

	// Set wins over the read-clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= {`EV_N{1'b0}};
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~{`EV_N{rd_stat}}) | ev;
			irq      <= |(irq_stat & irq_mask);
		end
	end

	// ----------------------------------------
	// LED feedback
	// ----------------------------------------
	wire           fb_act  = (fb_ms != 10'h000);
	wire           dark    = (gst == GS_DARK_D) | (gst == GS_DARK_F);
	wire           arm_s   = (gst == GS_ARM_D) | (gst == GS_CONF_D);
	wire           arm_f   = (gst == GS_ARM_F) | (gst == GS_CONF_F);
	wire [`NLED-1:0] all_on = {`NLED{1'b1}};
	wire [`NLED-1:0] norm  = `NLED'(1) << vid;
	logic [`NLED-1:0] next_led;

	// Three-blink counter: three on-phases of 128 ms each
	always_ff @(posedge aclk) begin
		if (!aresetn)
			fb_ms <= 10'h000;
		else if (fb_start)
			fb_ms <= 10'h001;
		else if (fb_act & tick)
			fb_ms <= (fb_ms == 10'(`FB_MS - 1)) ? 10'h000 : fb_ms + 10'd1;
	end

	// Priority: dark, three-blink, gesture blink, then normal routing
	always_comb begin
		if (dark)
			next_led = {`NLED{1'b0}};
		else if (fb_act)
			next_led = fb_ms[`FB_BIT] ? {`NLED{1'b0}} : all_on;
		else if (arm_s)
			next_led = ms_free[`SLOW_BIT] ? all_on : {`NLED{1'b0}};
		else if (arm_f)
			next_led = ms_free[`FAST_BIT] ? all_on : {`NLED{1'b0}};
		else
			next_led = norm;
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			led_front       <= {`NLED{1'b0}};
			heartbeat_led   <= 1'b0;
			video_route     <= 3'h0;
			audio_route     <= `AUD_EMB;
			embed_port      <= 2'h0;
			user_event      <= 1'b0;
			factory_restore <= 1'b0;
			reboot_req      <= 1'b0;
		end else begin
			led_front       <= next_led;
			heartbeat_led   <= ms_free[`SLOW_BIT];
			video_route     <= vid;
			audio_route     <= aud;
			embed_port      <= vid[1:0];
			user_event      <= user_ev;
			factory_restore <= fact_done;
			reboot_req      <= fact_done | r_rise;
		end
	end

endmodule : fpb_sequencer

`default_nettype wire

//--- dv/fpb_sequencer_chk.sv
/* Port checker for the button sequencer.
 * Assumes a bind into fpb_sequencer and a shortened tick. */
`timescale 1ns/1ps
`default_nettype none
`include "fpb_consts.svh"
module fpb_sequencer_chk
	import fpb_pkg::*;
#(
	parameter logic [16:0] P_TICK_CYC = 17'h0000A
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             btn_video,
	input wire logic             btn_reset,
	input wire fpb_vid_t         video_route,
	input wire logic [1:0]       embed_port,
	input wire logic [`NLED-1:0] led_front,
	input wire logic             heartbeat_led,
	input wire logic             dhcp_enable,
	input wire logic             user_event,
	input wire logic             factory_restore,
	input wire logic             reboot_req,
	input wire logic             bvalid,
	input wire logic             bready,
	input wire logic [1:0]       bresp
);
	// ----------------------------------------
	// Heartbeat half-period counter
	// ----------------------------------------
	localparam int HB_HALF = 512 * int'(P_TICK_CYC);
	logic hb_last;
	int   hb_cnt;
	// Restarts on each heartbeat edge; slack covers tick phase
	always_ff @(posedge aclk) begin
		hb_last <= aresetn ? heartbeat_led : 1'b0;
		hb_cnt  <= (!aresetn || heartbeat_led != hb_last) ? 0 : hb_cnt + 1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	AST_VID_STEP: assert property ($changed(video_route) |-> video_route == 3'h0 ||
		(video_route == $past(video_route) + 3'h1 && video_route <= 3'h4))
		else $error("video route left its sequence");
	AST_VID_CAUSE: assert property ($changed(video_route) && video_route != 3'h0 |->
		$past(btn_video, 3) || $past(btn_video, 4) || $past(btn_video, 5))
		else $error("video route moved without a press");
	AST_EMBED: assert property (video_route < 3'h4 && $stable(video_route) &&
		$past(video_route, 2) == video_route |-> embed_port == video_route[1:0])
		else $error("embedded audio port differs from video input");
	AST_DHCP_DARK: assert property ($rose(dhcp_enable) |-> ##[0:2] led_front == 5'h00)
		else $error("leds lit when dhcp came on");
	AST_FACTORY: assert property (factory_restore |-> reboot_req && !dhcp_enable)
		else $error("factory restore without reboot or with dhcp");
	AST_RESET_BTN: assert property ($rose(btn_reset) |-> ##[1:4] reboot_req)
		else $error("reset button gave no reboot");
	AST_KEEP: assert property (reboot_req && !factory_restore |->
		$stable(video_route) && $stable(dhcp_enable))
		else $error("plain reboot changed a setting");
	AST_HB_MAX: assert property (hb_cnt <= HB_HALF + 3)
		else $error("heartbeat stuck");
	AST_HB_MIN: assert property (heartbeat_led != hb_last |-> hb_cnt >= HB_HALF - 3)
		else $error("heartbeat too fast");
	AST_EVENT_PULSE: assert property (user_event |=> !user_event)
		else $error("user event longer than one cycle");
	AST_BRESP_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
endmodule : fpb_sequencer_chk
bind fpb_sequencer fpb_sequencer_chk #(.P_TICK_CYC(P_TICK_CYC)) chk_u (.aclk(aclk),
	.aresetn(aresetn), .btn_video(btn_video), .btn_reset(btn_reset),
	.video_route(video_route), .embed_port(embed_port), .led_front(led_front),
	.heartbeat_led(heartbeat_led), .dhcp_enable(dhcp_enable), .user_event(user_event),
	.factory_restore(factory_restore), .reboot_req(reboot_req), .bvalid(bvalid),
	.bready(bready), .bresp(bresp));
`default_nettype wire

//--- dv/fpb_panel_model.sv
/* Front panel: a person pressing buttons and watching the leds.
 * Assumes the bench calls its tasks right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
`include "fpb_consts.svh"
module fpb_panel_model (
	input wire logic             aclk,
	input wire logic [`NLED-1:0] led_front,
	output var logic             btn_video,
	output var logic             btn_audio,
	output var logic             user_action_button,
	output var logic             btn_reset
);
	int   blinks;
	logic lit_q;
	// Released buttons read low; blinks count lit-to-dark falls
	initial begin
		{btn_reset, user_action_button, btn_audio, btn_video} = 4'h0;
		blinks = 0;
		lit_q = 1'b0;
	end
	always @(posedge aclk) begin
		lit_q <= |led_front;
		if (lit_q && !(|led_front)) blinks++;
	end
	// Mask order {reset, user, audio, video}; audio and user both set is a combo press
	task automatic press(input logic [3:0] m, input int hi, input int lo);
		@(posedge aclk);
		{btn_reset, user_action_button, btn_audio, btn_video} <= m;
		repeat (hi) @(posedge aclk);
		{btn_reset, user_action_button, btn_audio, btn_video} <= 4'h0;
		repeat (lo) @(posedge aclk);
	endtask : press
	// Quick presses, well inside the confirm window
	task automatic confirm(input int n);
		for (int i = 0; i < n; i++) press(4'h4, 3, 3);
	endtask : confirm
endmodule : fpb_panel_model
`default_nettype wire

//--- dv/fpb_sequencer_bench.sv
/* Self-checking bench of the button sequencer against an integer model.
 * Assumes a 10-cycle tick so the gestures fit a short run. */
`timescale 1ns/1ps
`default_nettype none
`include "fpb_consts.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module fpb_sequencer_bench
	import fpb_pkg::*;
;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
	logic        bvalid, arready, rvalid, heartbeat_led, dhcp_enable, user_event, irq;
	logic        factory_restore, reboot_req, btn_video, btn_audio, user_action_button, btn_reset;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, e_ana;
	logic [1:0]  bresp, rresp, embed_port;
	logic [4:0]  led_front;
	fpb_vid_t    video_route;
	fpb_aud_t    audio_route;
	int          bad_count, total_checks, cyc, e_vid, e_aud, e_lock, e_dhcp, rb_n, fr_n, n;
	int          hist[$];
	fpb_sequencer #(.P_TICK_CYC(17'h0000A), .P_HOLD_SLOW_MS(14'h5), .P_HOLD_FAST_MS(14'hA),
		.P_CONFIRM_MS(14'h4)) dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .btn_video(btn_video), .btn_audio(btn_audio),
		.user_action_button(user_action_button), .btn_reset(btn_reset),
		.video_route(video_route), .audio_route(audio_route), .embed_port(embed_port),
		.led_front(led_front), .heartbeat_led(heartbeat_led), .dhcp_enable(dhcp_enable),
		.user_event(user_event), .factory_restore(factory_restore), .reboot_req(reboot_req),
		.irq(irq));
	fpb_panel_model panel_u (.aclk(aclk), .led_front(led_front), .btn_video(btn_video),
		.btn_audio(btn_audio), .user_action_button(user_action_button), .btn_reset(btn_reset));
	// ----------------------------------------
	// Clock, watchdog and pulse counters
	// ----------------------------------------
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Run needs about 60000 cycles; 90000 leaves margin
	always @(posedge aclk) begin
		cyc++;
		if (reboot_req) rb_n++;
		if (factory_restore) fr_n++;
		if (cyc == 90000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------
	// Register bus tasks and reference model
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
		// Random upper strobes; byte 0 always enabled so the write lands
		wstrb  <= 4'($urandom) | 4'h1;
		bready <= d[0];
		do begin
			@(posedge aclk);
			k++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (!bready) bready <= 1'b1;
		end while (!(bvalid && bready) && k < 100);
		bready <= 1'b0;
		`CHK(bresp, `RESP_OKAY)
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int k;
		k = 0;
		@(posedge aclk);
		{araddr, arvalid} <= {a, 1'b1};
		// Ready may come late; the slave must hold its answer meanwhile
		rready <= a[2];
		do begin
			@(posedge aclk);
			k++;
			if (arready) arvalid <= 1'b0;
			if (!rready) rready <= 1'b1;
		end while (!(rvalid && rready) && k < 100);
		rready <= 1'b0;
		`CHK(rdata, e)
		`CHK(rresp, er)
	endtask : rd
	function automatic logic [31:0] st();
		return 32'(e_vid) | (32'(e_aud) << 4) | (32'(e_dhcp) << 6) | (32'(e_lock) << 7);
	endfunction : st
	// Analog inputs carry no embedded audio; autoselect counts as digital
	function automatic int nxt_aud(int a);
		int v;
		v = (a + 1) % 3;
		if (v == 0 && e_vid < 4 && e_ana[e_vid[1:0]]) v = 1;
		return v;
	endfunction : nxt_aud
	task automatic vid_press();
		panel_u.press(4'h1, 2 + $urandom_range(0, 3), 12);
		e_vid = (e_vid == 4) ? 0 : e_vid + 1;
		hist.push_back(e_vid);
	endtask : vid_press
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{e_vid, e_aud, e_lock, e_dhcp, rb_n, fr_n} = {6{32'sd0}};
		n = $urandom(21471);
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK(led_front, 5'h01)
		rd(`REG_STATUS, st(), `RESP_OKAY);
		rd(`REG_ANALOG, 32'h1, `RESP_OKAY);
		rd(`REG_IRQ_MASK, 32'h0, `RESP_OKAY);
		rd(8'h14, 32'h0, `RESP_SLVERR);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			vid_press();
			`CHK(video_route, 3'(hist[$]))
			`CHK(led_front, 5'(5'h01 << e_vid))
		end
		rd(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
		wr(`REG_IRQ_MASK, 32'h1);
		vid_press();
		`CHK(irq, 1'b1)
		rd(`REG_IRQ_STAT, 32'h1, `RESP_OKAY);
		repeat (3) @(posedge aclk);
		`CHK(irq, 1'b0)
		wr(`REG_IRQ_MASK, 32'h0);
		vid_press();
		`CHK(irq, 1'b0)
		$display("test video done");
		e_ana = 4'($urandom_range(0, 15));
		e_ana[e_vid[1:0]] = 1'b1;
		wr(`REG_ANALOG, 32'(e_ana));
		for (int i = 0; i < 5; i++) begin
			if (i == 4) vid_press();
			panel_u.press(4'h2, 3, 1100);
			e_aud = nxt_aud(e_aud);
			`CHK(audio_route, 2'(e_aud))
			`CHK(embed_port, 2'(e_vid == 4 ? 0 : e_vid))
		end
		wr(`REG_CTRL, 32'h3);
		panel_u.press(4'h1, 3, 12);
		panel_u.press(4'h2, 3, 1100);
		rd(`REG_STATUS, st(), `RESP_OKAY);
		wr(`REG_CTRL, 32'h0);
		$display("test audio done");
		panel_u.blinks = 0;
		panel_u.press(4'h6, 5, 9300);
		e_lock = 1;
		`CHK(panel_u.blinks, 3)
		rd(`REG_STATUS, st(), `RESP_OKAY);
		panel_u.blinks = 0;
		panel_u.press(4'h1, 3, 8000);
		`CHK(video_route, 3'(e_vid))
		`CHK(panel_u.blinks, 3)
		panel_u.press(4'h6, 5, 9300);
		e_lock = 0;
		rd(`REG_STATUS, st(), `RESP_OKAY);
		$display("test lock done");
		panel_u.press(4'h4, 3, 0);
		for (n = 0; !user_event && n < 1200; n++) @(posedge aclk);
		`CHK(user_event, 1'b1)
		panel_u.press(4'h4, 60, 5);
		panel_u.confirm(2);
		repeat (100) @(posedge aclk);
		`CHK(dhcp_enable, 1'b0)
		`CHK(led_front, 5'(5'h01 << e_vid))
		panel_u.press(4'h4, 60, 5);
		panel_u.confirm(3);
		for (n = 0; !dhcp_enable && n < 60; n++) @(posedge aclk);
		`CHK(dhcp_enable, 1'b1)
		repeat (3) @(posedge aclk);
		`CHK(led_front, 5'h00)
		e_dhcp = 1;
		repeat (10500) @(posedge aclk);
		rd(`REG_STATUS, st(), `RESP_OKAY);
		$display("test dhcp done");
		panel_u.press(4'h4, 120, 5);
		panel_u.confirm(3);
		for (n = 0; !factory_restore && n < 12000; n++) @(posedge aclk);
		`CHK(factory_restore, 1'b1)
		{e_vid, e_aud, e_dhcp} = {3{32'sd0}};
		repeat (5) @(posedge aclk);
		rd(`REG_STATUS, st(), `RESP_OKAY);
		rd(`REG_ANALOG, 32'h1, `RESP_OKAY);
		vid_press();
		vid_press();
		n = fr_n;
		panel_u.press(4'h8, 3, 10);
		`CHK(rb_n, 2)
		`CHK(fr_n, n)
		`CHK(video_route, 3'(e_vid))
		$display("test factory and reset done");
		report_and_stop();
	end
endmodule : fpb_sequencer_bench
`default_nettype wire
